//--- hw/crs_pkg.sv
package crs_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_PTR_UPPER = 8'hBE;
    localparam logic [7:0] IDX_PTR_LOWER = 8'hBF;
    localparam logic [7:0] IDX_STACK_PTR = 8'hC0;
    localparam logic [7:0] IDX_FLAGS = 8'hC1;
    localparam logic [7:0] IDX_WORK = 8'hC2;
    localparam logic [7:0] IDX_INSTR = 8'hC3;

    // ****************************************************************
    // Flags register layout
    // ****************************************************************
    localparam int FLG_CARRY = 0;
    localparam int FLG_NIBBLE = 1;
    localparam int FLG_NULL = 2;
    localparam int FLG_MSB = 3;
    localparam int FLG_IRQ = 4;
    localparam int FLG_BUSY = 5;
    // Bits software may write; the busy bit only reflects hardware
    localparam logic [7:0] FLG_WR_MASK = 8'h1F;

    // ****************************************************************
    // Reset values and address constants
    // ****************************************************************
    localparam logic [11:0] PC_RESET = 12'h800;
    localparam logic [3:0] SP_RESET = 4'hF;
    localparam logic [7:0] STACK_BASE = 8'h30;
    localparam logic [3:0] SP_STEP = 4'h2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] WORK_RESET = 8'h00;
    localparam logic [11:0] PTR_RESET = 12'h000;

    // Interrupt entry takes this many instruction cycles in total
    localparam int IRQ_ENTRY_CYCLES = 5;

    // Interrupt source identifiers, highest priority first
    localparam logic [1:0] SRC_WAKE = 2'h3;
    localparam logic [1:0] SRC_TMR0 = 2'h2;
    localparam logic [1:0] SRC_TMR1 = 2'h1;
    localparam logic [1:0] SRC_SOFT = 2'h0;

    // ****************************************************************
    // Operations issued by the instruction decoder
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_NONE = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_AND = 5'h03,
        OP_OR = 5'h04, OP_XOR = 5'h05, OP_LOAD = 5'h06, OP_RLC = 5'h07,
        OP_RRC = 5'h08, OP_SET_C = 5'h09, OP_CLR_C = 5'h0A,
        OP_LOAD_C = 5'h0B, OP_FLIP_C = 5'h0C, OP_PTR_LOAD = 5'h0D,
        OP_PTR_INC = 5'h0E, OP_PTR_DEC = 5'h0F, OP_CALL = 5'h10,
        OP_RET = 5'h11, OP_ISR_EXIT = 5'h12, OP_IRQ_ON = 5'h13,
        OP_IRQ_OFF = 5'h14, OP_JUMP = 5'h15
    } crs_op_t;

    // One decoded instruction step from the decoder
    typedef struct packed {
        crs_op_t op;          // Operation
        logic [7:0] operand;  // Data operand
        logic [11:0] addr;    // Pointer value or jump/call target
        logic [2:0] bit_sel;  // Bit picked by load_carry
        logic use_carry;      // Add or subtract with carry in
        logic pc_step;        // Advance instr_pointer by one
        logic ea_valid;       // Indexed access requested
        logic ea_write;       // Indexed access is a write
        logic [7:0] offset;   // Indexed offset
    } crs_core_req_t;

    // Effective address handed to the memory system
    typedef struct packed {
        logic valid;          // One-cycle strobe
        logic write;          // Write, already blocked in code space
        logic [11:0] addr;    // Space bit and address
    } crs_eff_t;

endpackage : crs_pkg

//--- hw/crs_cpu_regs.sv
`timescale 1ns/1ps
// Overview of operation
// RULE1: Eight-bit work register holds operands, results.
// RULE2: Pointer, stack pointer, flags reachable by memory.
// RULE3: Effective address is pointer plus offset.
// RULE4: Pointer writes into code space are dropped.
// RULE5: Pointer upper at 0xBE, lower at 0xBF.
// RULE6: Pointer bit eleven write-only, selects space.
// RULE7: Counting touches only low eleven pointer bits.
// RULE8: Twelve-bit instr_pointer resets to 0x800.
// RULE9: Four-bit stack_ptr resets to 0xF.
// RULE10: Stack grows down by two per address.
// RULE11: Call pushes low byte first; exit pulls.
// RULE12: Flags register holds six status bits.
// RULE13: Carry from arithmetic, rotates, direct carry ops.
// RULE14: Nibble carry on low nibble overflow.
// RULE15: Null flag set when result is zero.
// RULE16: Msb flag copies result top bit.
// RULE17: Maskable requests wait while irq_allow clear.
// RULE18: Reset clears irq_allow; only software sets.
// RULE19: Clear irq_allow after stacking and vector fetch.
// RULE20: isr_exit restores pointer, sets irq_allow.
// RULE21: Interrupt entry takes five instruction cycles.
// RULE22: Priority wake, timer0, timer1, software last.
// RULE23: Stack location is 0x30 plus stack_ptr.
// RULE24: Busy flag mirrors data memory write progress.
module crs_cpu_regs
    import crs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire crs_core_req_t core_req,
    input wire logic instr_done,
    input wire logic nvm_write_busy,
    input wire logic req_wake,
    input wire logic req_tmr0,
    input wire logic req_tmr1,
    input wire logic req_soft,
    input wire logic [10:0] vector_addr,
    output logic [7:0] work_reg,
    output logic [11:0] ptr_reg,
    output logic [7:0] flags_reg,
    output logic [3:0] stack_ptr,
    output logic [11:0] instr_pointer,
    output crs_eff_t eff_out,
    output logic [1:0] vector_id,
    output logic vector_fetch,
    output logic irq_busy
);

    // ****************************************************************
    // Interrupt entry sequencer states
    // ****************************************************************
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_PUSH_LO = 6'b000010,
        ST_PUSH_HI = 6'b000100,
        ST_FETCH = 6'b001000,
        ST_LOAD = 6'b010000,
        ST_FINISH = 6'b100000
    } crs_state_t;

    crs_state_t state;         // Current sequencer state
    crs_state_t next_state;    // Next sequencer state

    // Stack storage, sixteen bytes at 0x30..0x3F
    logic [7:0] stack_mem [0:15];
    logic [10:0] pc;           // Program space offset of next fetch
    logic [10:0] saved_pc;     // Return address during entry
    logic [1:0] src_latched;   // Source being entered

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire [7:0] idx = paddr[ADDR_W-1:2];
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire hit_upper = idx == IDX_PTR_UPPER;
    wire hit_lower = idx == IDX_PTR_LOWER;
    wire hit_sp = idx == IDX_STACK_PTR;
    wire hit_flags = idx == IDX_FLAGS;
    wire hit_work = idx == IDX_WORK;
    wire hit_pc = idx == IDX_INSTR;
    wire mapped = hit_upper || hit_lower || hit_sp || hit_flags ||
                  hit_work || hit_pc;
    // Writes land only on the access edge with pready high
    wire bus_wr = access && pwrite && !pslverr;
    wire wr_upper = bus_wr && hit_upper;
    wire wr_lower = bus_wr && hit_lower;
    wire wr_sp = bus_wr && hit_sp;
    wire wr_flags = bus_wr && hit_flags;

    // Read mux; bit eleven of the pointer is never visible
    // RULE5: pointer halves
    // RULE6: space bit hidden
    wire [7:0] rd_upper = {5'h00, ptr_reg[10:8]};
    wire [DATA_W-1:0] rd_data =
        hit_upper ? {24'h000000, rd_upper} :
        hit_lower ? {24'h000000, ptr_reg[7:0]} :
        hit_sp ? {28'h0000000, stack_ptr} :
        hit_flags ? {24'h000000, flags_reg} :
        hit_work ? {24'h000000, work_reg} :
        hit_pc ? {20'h00000, instr_pointer} : 32'h00000000;

    // ****************************************************************
    // Arithmetic and flag results
    // ****************************************************************
    crs_op_t op;
    // Decoder steps are ignored while interrupt entry owns the core
    assign op = irq_busy ? OP_NONE : core_req.op;
    wire cin = core_req.use_carry && flags_reg[FLG_CARRY];
    wire [7:0] opnd = core_req.operand;
    // RULE13: carry out of add
    wire [8:0] sum9 = {1'b0, work_reg} + {1'b0, opnd} + {8'h00, cin};
    // RULE14: nibble carry from low half
    wire [4:0] sum5 = {1'b0, work_reg[3:0]} + {1'b0, opnd[3:0]} +
                      {4'h0, cin};
    wire [8:0] dif9 = {1'b0, work_reg} - {1'b0, opnd} - {8'h00, cin};
    wire [4:0] dif5 = {1'b0, work_reg[3:0]} - {1'b0, opnd[3:0]} -
                      {4'h0, cin};
    wire is_add = op == OP_ADD;
    wire is_sub = op == OP_SUB;
    wire is_rot = op == OP_RLC || op == OP_RRC;
    wire is_logic = op == OP_AND || op == OP_OR || op == OP_XOR ||
                    op == OP_LOAD;
    wire writes_work = is_add || is_sub || is_rot || is_logic;
    // RULE1: work register result select
    wire [7:0] alu_res =
        is_add ? sum9[7:0] :
        is_sub ? dif9[7:0] :
        op == OP_AND ? (work_reg & opnd) :
        op == OP_OR ? (work_reg | opnd) :
        op == OP_XOR ? (work_reg ^ opnd) :
        op == OP_RLC ? {work_reg[6:0], flags_reg[FLG_CARRY]} :
        op == OP_RRC ? {flags_reg[FLG_CARRY], work_reg[7:1]} : opnd;

    // RULE13: rotates pass through carry
    wire rot_out = (op == OP_RLC) ? work_reg[7] : work_reg[0];

    // ****************************************************************
    // Interrupt arbitration
    // ****************************************************************
    // RULE17: maskable requests gated
    wire irq_on = flags_reg[FLG_IRQ];
    wire take_wake = req_wake && irq_on;
    wire take_t0 = req_tmr0 && irq_on;
    wire take_t1 = req_tmr1 && irq_on;
    // Software request ignores the global allow bit
    wire any_irq = take_wake || take_t0 || take_t1 || req_soft;
    // RULE22: fixed priority order
    wire [1:0] win_src = take_wake ? SRC_WAKE :
                         take_t0 ? SRC_TMR0 :
                         take_t1 ? SRC_TMR1 : SRC_SOFT;
    // RULE21: entry only at instruction boundary
    wire start_irq = (state == ST_IDLE) && instr_done && any_irq;

    // ****************************************************************
    // Stack addressing
    // ****************************************************************
    // RULE10: down by two on push
    wire [3:0] sp_dec = stack_ptr - SP_STEP;
    wire [3:0] sp_inc = stack_ptr + SP_STEP;
    wire [3:0] sp_hi_push = stack_ptr - 4'h1;
    wire [3:0] sp_lo_pull = sp_inc;
    wire [3:0] sp_hi_pull = sp_inc - 4'h1;
    wire is_call = op == OP_CALL;
    wire is_pull = op == OP_RET || op == OP_ISR_EXIT;
    // RULE11: recovered return address
    wire [10:0] pulled = {stack_mem[sp_hi_pull][2:0],
                          stack_mem[sp_lo_pull]};
    wire [10:0] pc_plus = pc + 11'h001;
    // Return address pushed by a call is the next fetch address
    wire [10:0] ret_addr = core_req.pc_step ? pc_plus : pc;
    // RULE8: reset to program space start
    // RULE20: pull restores pointer
    wire [10:0] next_pc = (state == ST_LOAD) ? vector_addr :
                          is_pull ? pulled :
                          (is_call || op == OP_JUMP) ? core_req.addr[10:0] :
                          (op != OP_NONE && core_req.pc_step) ? pc_plus :
                          pc;

    // RULE3: offset added to low bits
    // RULE7: space bit kept apart
    wire [10:0] ea_low = ptr_reg[10:0] + {3'h0, core_req.offset};
    wire [10:0] ptr_low_inc = ptr_reg[10:0] + 11'h001;
    wire [10:0] ptr_low_dec = ptr_reg[10:0] - 11'h001;

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (start_irq)
                    next_state = ST_PUSH_LO;
            end
            ST_PUSH_LO: next_state = ST_PUSH_HI;
            ST_PUSH_HI: next_state = ST_FETCH;
            ST_FETCH: next_state = ST_LOAD;
            ST_LOAD: next_state = ST_FINISH;
            ST_FINISH: next_state = ST_IDLE;
            // Recover from a corrupted one-hot code
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // Busy covers the five entry cycles
    // RULE21: five cycle entry
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_busy <= 1'b0;
        else
            irq_busy <= (next_state != ST_IDLE);
    end

    // Source and return address captured at entry start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_latched <= SRC_SOFT;
            saved_pc <= 11'h000;
        end
        else if (start_irq)
        begin
            src_latched <= win_src;
            saved_pc <= pc;
        end
    end

    // Vector request towards the vector table
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vector_id <= SRC_SOFT;
            vector_fetch <= 1'b0;
        end
        else
        begin
            vector_id <= src_latched;
            vector_fetch <= (next_state == ST_FETCH);
        end
    end

    // ****************************************************************
    // Stack memory and stack pointer
    // ****************************************************************
    // Pushes from a call or interrupt entry, low byte at the top
    // RULE23: stack_ptr picks a byte of 0x30..0x3F
    // RULE11: low byte first
    always_ff @(posedge pclk)
    begin
        if (is_call)
        begin
            stack_mem[stack_ptr] <= ret_addr[7:0];
            stack_mem[sp_hi_push] <= {5'h00, ret_addr[10:8]};
        end
        else if (state == ST_PUSH_LO)
            stack_mem[stack_ptr] <= saved_pc[7:0];
        else if (state == ST_PUSH_HI)
            stack_mem[stack_ptr] <= {5'h00, saved_pc[10:8]};
    end

    // Stack pointer: bus load, push and pull
    // RULE9: reset to top
    // RULE10: step of two per address
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            stack_ptr <= SP_RESET;
        else if (is_call)
            stack_ptr <= sp_dec;
        else if (is_pull)
            stack_ptr <= sp_inc;
        else if (state == ST_PUSH_LO || state == ST_PUSH_HI)
            stack_ptr <= stack_ptr - 4'h1;
        // RULE2: memory-mapped stack pointer
        else if (wr_sp)
            stack_ptr <= pwdata[3:0];
    end

    // ****************************************************************
    // Program counter
    // ****************************************************************
    // One next value feeds both copies, so they can never disagree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pc <= PC_RESET[10:0];
            instr_pointer <= PC_RESET;
        end
        else
        begin
            pc <= next_pc;
            instr_pointer <= {1'b1, next_pc};
        end
    end

    // ****************************************************************
    // Work register and pointer
    // ****************************************************************
    // RULE1: result capture
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            work_reg <= WORK_RESET;
        else if (writes_work)
            work_reg <= alu_res;
    end

    // Pointer: full load, counting, and bus halves
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ptr_reg <= PTR_RESET;
        else if (op == OP_PTR_LOAD)
            ptr_reg <= core_req.addr;
        // RULE7: counting keeps the space bit
        else if (op == OP_PTR_INC)
            ptr_reg <= {ptr_reg[11], ptr_low_inc};
        else if (op == OP_PTR_DEC)
            ptr_reg <= {ptr_reg[11], ptr_low_dec};
        // RULE5: upper nibble at its own address
        else if (wr_upper)
            ptr_reg <= {pwdata[3:0], ptr_reg[7:0]};
        else if (wr_lower)
            ptr_reg <= {ptr_reg[11:8], pwdata[7:0]};
    end

    // Indexed access strobe
    // RULE4: code space stays read-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            eff_out <= '0;
        else
        begin
            eff_out.valid <= core_req.ea_valid && !irq_busy;
            eff_out.write <= core_req.ea_valid && !irq_busy &&
                             core_req.ea_write && !ptr_reg[11];
            eff_out.addr <= {ptr_reg[11], ea_low};
        end
    end

    // ****************************************************************
    // Flags register
    // ****************************************************************
    // RULE12: six status bits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            // RULE18: reset clears irq_allow
            flags_reg <= FLAGS_RESET;
        else
        begin
            // RULE24: busy mirrors data memory write
            flags_reg[FLG_BUSY] <= nvm_write_busy;
            flags_reg[7:6] <= 2'h0;
            if (wr_flags)
                flags_reg[4:0] <= pwdata[4:0] & FLG_WR_MASK[4:0];
            // RULE13: carry sources
            if (is_add)
                flags_reg[FLG_CARRY] <= sum9[8];
            else if (is_sub)
                flags_reg[FLG_CARRY] <= dif9[8];
            else if (is_rot)
                flags_reg[FLG_CARRY] <= rot_out;
            else if (op == OP_SET_C)
                flags_reg[FLG_CARRY] <= 1'b1;
            else if (op == OP_CLR_C)
                flags_reg[FLG_CARRY] <= 1'b0;
            else if (op == OP_LOAD_C)
                flags_reg[FLG_CARRY] <= opnd[core_req.bit_sel];
            else if (op == OP_FLIP_C)
                flags_reg[FLG_CARRY] <= !flags_reg[FLG_CARRY];
            // RULE14: nibble carry
            if (is_add)
                flags_reg[FLG_NIBBLE] <= sum5[4];
            else if (is_sub)
                flags_reg[FLG_NIBBLE] <= dif5[4];
            if (writes_work)
            begin
                // RULE15: zero result
                flags_reg[FLG_NULL] <= (alu_res == 8'h00);
                // RULE16: top bit of result
                flags_reg[FLG_MSB] <= alu_res[7];
            end
            // RULE19: cleared once vector fetched
            if (state == ST_LOAD)
                flags_reg[FLG_IRQ] <= 1'b0;
            // RULE20: isr_exit sets irq_allow
            else if (op == OP_ISR_EXIT || op == OP_IRQ_ON)
                flags_reg[FLG_IRQ] <= 1'b1;
            else if (op == OP_IRQ_OFF)
                flags_reg[FLG_IRQ] <= 1'b0;
        end
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************
    // Answer in the first access cycle; unmapped gives an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !mapped;
            // RULE2: memory-mapped read
            if (setup && !pwrite)
                prdata <= rd_data;
        end
    end

endmodule : crs_cpu_regs

//--- sim/crs_cpu_regs_monitor.sv
`timescale 1ns/1ps
// ********************
// Port checker
// ********************
module crs_cpu_regs_monitor
    import crs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic instr_done,
    input wire logic nvm_write_busy,
    input wire logic req_tmr0,
    input wire logic req_soft,
    input wire logic [10:0] vector_addr,
    input wire logic [7:0] flags_reg,
    input wire logic [11:0] instr_pointer,
    input wire logic vector_fetch,
    input wire logic irq_busy
);
    // One domain, so one default clock and reset
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_entry_len: assert property ($rose(irq_busy) |->
        irq_busy [*5] ##1 !irq_busy) else $error("entry not five cycles");
    a_fetch_slot: assert property ($rose(irq_busy) |->
        ##[1:3] vector_fetch) else $error("vector fetch missing");
    a_vec_load: assert property (vector_fetch |->
        ##[1:3] instr_pointer == {1'h1, vector_addr})
        else $error("vector not loaded");
    a_allow_off: assert property ($fell(irq_busy) |->
        !flags_reg[FLG_IRQ]) else $error("allow bit left set");
    a_busy_lag: assert property (1'h1 |=>
        flags_reg[FLG_BUSY] == $past(nvm_write_busy))
        else $error("busy flag wrong");
    // Masked request with no software request must not start entry
    a_mask_hold: assert property (instr_done && !flags_reg[FLG_IRQ]
        && !req_soft && !irq_busy |=> !irq_busy)
        else $error("masked request served");
    a_irq_take: assert property (instr_done && flags_reg[FLG_IRQ]
        && req_tmr0 && !irq_busy |=> irq_busy)
        else $error("allowed request ignored");

    cover property ($rose(irq_busy));
    cover property (pslverr);
    cover property (pready && !pslverr);
endmodule : crs_cpu_regs_monitor

bind crs_cpu_regs crs_cpu_regs_monitor i_mon (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .instr_done,
    .nvm_write_busy, .req_tmr0, .req_soft, .vector_addr, .flags_reg,
    .instr_pointer, .vector_fetch, .irq_busy);

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench
    import crs_pkg::*;
;
    // Row: address, write data, expected read, expected error
    typedef struct packed {
        logic [9:0] a;
        logic [7:0] d;
        logic [7:0] r;
        logic e;
    } crs_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic instr_done, nvm_write_busy, req_wake, req_tmr0, req_tmr1;
    logic req_soft, vector_fetch, irq_busy;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] vector_addr;
    logic [7:0] work_reg, flags_reg;
    logic [11:0] ptr_reg, instr_pointer;
    logic [3:0] stack_ptr;
    logic [1:0] vector_id;
    crs_core_req_t core_req, rq;
    crs_eff_t eff_out;
    int n_mismatch = 0;
    int compares = 0;
    // Work register is read-only; the last row hits a hole in the map
    crs_row_t rows [6] = '{
        '{10'h2FC, 8'hA5, 8'hA5, 1'h0}, '{10'h2F8, 8'h0F, 8'h07, 1'h0},
        '{10'h300, 8'h05, 8'h05, 1'h0}, '{10'h304, 8'hFF, 8'h1F, 1'h0},
        '{10'h308, 8'h5A, 8'h00, 1'h0}, '{10'h3FC, 8'h11, 8'h00, 1'h1}};

    crs_cpu_regs i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_req, .instr_done,
        .nvm_write_busy, .req_wake, .req_tmr0, .req_tmr1, .req_soft,
        .vector_addr, .work_reg, .ptr_reg, .flags_reg, .stack_ptr,
        .instr_pointer, .eff_out, .vector_id, .vector_fetch, .irq_busy);

    // ********************
    // Helpers
    // ********************
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask : chk

    task rst;
        presetn <= 1'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
    endtask : rst

    // Holds the request until ready is sampled high, no fixed latency
    task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        for (n = 0; n < 20 && pready !== 1'h1; n++)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // One decoder step; returns once its results are visible
    task core(input crs_op_t op, input logic [7:0] v);
        @(posedge pclk);
        rq.op = op;
        rq.operand = v;
        core_req <= rq;
        @(posedge pclk);
        core_req.op <= OP_NONE;
        @(posedge pclk);
    endtask : core

    task irq(input logic [3:0] m, input logic [1:0] id);
        int n;
        @(posedge pclk);
        {req_wake, req_tmr0, req_tmr1, req_soft} <= m;
        instr_done <= 1'h1;
        for (n = 0; n < 20 && irq_busy !== 1'h1; n++)
            @(posedge pclk);
        {req_wake, req_tmr0, req_tmr1, req_soft, instr_done} <= 5'h0;
        for (n = 0; n < 20 && vector_fetch !== 1'h1; n++)
            @(posedge pclk);
        chk("source", vector_id, id);
        for (n = 0; n < 20 && irq_busy !== 1'h0; n++)
            @(posedge pclk);
        chk("pc", instr_pointer, 12'h923);
        chk("sp", stack_ptr, 4'hD);
        chk("allow", flags_reg[FLG_IRQ], 1'h0);
        core(OP_ISR_EXIT, 8'h00);
        chk("pc", instr_pointer, 12'h801);
        chk("allow", flags_reg[FLG_IRQ], 1'h1);
    endtask : irq

    task close_out;
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // Whole run is well under two hundred cycles
    initial
    begin
        #20000;
        n_mismatch++;
        close_out;
    end

    // ********************
    // Main sequence
    // ********************
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {instr_done, nvm_write_busy, req_wake, req_tmr0} = '0;
        {req_tmr1, req_soft} = '0;
        core_req = '0;
        rq = '0;
        vector_addr = 11'h123;
        rst;
        chk("sp", stack_ptr, 4'hF);
        chk("pc", instr_pointer, 12'h800);
        chk("flags", flags_reg, 8'h00);
        nvm_write_busy <= 1'h1;
        repeat (2) @(posedge pclk);
        chk("busy", flags_reg[FLG_BUSY], 1'h1);
        nvm_write_busy <= 1'h0;
        foreach (rows[i])
        begin
            apb(1'h1, rows[i].a, {24'h0, rows[i].d});
            apb(1'h0, rows[i].a, 32'h0);
            chk("rdata", rd, {24'h0, rows[i].r});
            chk("slverr", err, rows[i].e);
        end
        chk("ptr", ptr_reg, 12'hFA5);
        // Indexed write into code space wraps in 11 bits, never writes
        rq.ea_valid = 1'h1;
        rq.ea_write = 1'h1;
        rq.offset = 8'h60;
        core(OP_LOAD, 8'h00);
        chk("eff", eff_out, {1'h1, 1'h0, 12'h805});
        rq.ea_valid = 1'h0;
        apb(1'h1, 10'h2FC, 32'hFF);
        core(OP_PTR_INC, 8'h00);
        chk("ptr", ptr_reg, 12'h800);
        rst;
        {instr_done, req_tmr1} <= 2'h3;
        repeat (4) @(posedge pclk);
        chk("irq_busy", irq_busy, 1'h0);
        {instr_done, req_tmr1} <= 2'h0;
        core(OP_LOAD, 8'h8F);
        core(OP_ADD, 8'h71);
        chk("acc", work_reg, 8'h00);
        chk("cc", flags_reg[3:0], 4'h7);
        core(OP_ADD, 8'h80);
        chk("cc", flags_reg[3:0], 4'h8);
        core(OP_FLIP_C, 8'h00);
        chk("cc", flags_reg[3:0], 4'h9);
        rq.addr = 12'h9AB;
        rq.pc_step = 1'h1;
        core(OP_CALL, 8'h00);
        chk("sp", stack_ptr, 4'hD);
        chk("pc", instr_pointer, 12'h9AB);
        rq.pc_step = 1'h0;
        core(OP_RET, 8'h00);
        chk("pc", instr_pointer, 12'h801);
        chk("sp", stack_ptr, 4'hF);
        core(OP_IRQ_ON, 8'h00);
        chk("allow", flags_reg[FLG_IRQ], 1'h1);
        // Each pass raises one source with all lower ones beside it
        for (int k = 3; k >= 0; k--)
        begin
            irq(4'hF >> (3 - k), k[1:0]);
        end
        close_out;
    end
endmodule : testbench
